/* File: hw/fbp_consts.svh */
// constants for the filter buffer pointer block
`ifndef FBP_CONSTS_SVH
`define FBP_CONSTS_SVH

// ==========================================================================
// register byte offsets
`define OFF_PTR_4_7 8'h00
`define OFF_PTR_8_11 8'h04
`define OFF_FILTER_EN 8'h08
`define OFF_ROUTE_STATUS 8'h0C

// ==========================================================================
// reset values
`define RST_PTR 16'h0000
`define RST_FILTER_EN 16'hFFFF

// ==========================================================================
// field positions
`define FIELD_W 4
`define FIRST_FILTER 4'h4
`define LAST_FILTER 4'hB
`define STAT_BUF_LSB 0
`define STAT_FIFO_BIT 4
`define STAT_SEEN_BIT 5
`define STAT_FILTER_LSB 8

// ==========================================================================
// destination encoding
`define DEST_FIFO_CODE 4'hF
`define DEST_LAST_BUFFER 4'hE

`endif

/* File: hw/fbp_pkg.sv */
// types shared by the filter buffer pointer block
package fbp_pkg;
   typedef logic [3:0] dest_code_t;
   typedef logic [3:0] filter_index_t;
   typedef logic [15:0] ptr_reg_t;
   typedef logic [31:0] bus_word_t;
endpackage

/* File: hw/dest_decode.sv */
// decodes one pointer nibble into a receive destination
`timescale 1ns/1ps
`include "fbp_consts.svh"
module dest_decode
   import fbp_pkg::*;
(
   // pointer code
   input wire fbp_pkg::dest_code_t code,
   // destination
   output logic to_fifo,
   output fbp_pkg::dest_code_t buffer_index
);
   // same decode serves every field, so no field can differ in meaning
   always_comb begin
      to_fifo = (code == `DEST_FIFO_CODE);
      buffer_index = to_fifo ? 4'h0 : code;
   end
endmodule

/* File: hw/can_filter_buffer_pointer.sv */
// buffer pointer registers for filters 4-11 with AHB-Lite access and hit routing
`timescale 1ns/1ps
`include "fbp_consts.svh"
module can_filter_buffer_pointer
   import fbp_pkg::*;
(
   // clock, reset, enable
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic ce,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire fbp_pkg::bus_word_t hwdata,
   input wire logic hready,
   output logic hreadyout,
   output fbp_pkg::bus_word_t hrdata,
   output logic hresp,
   // filter match side
   input wire logic hit_valid,
   input wire fbp_pkg::filter_index_t hit_index,
   // buffer write side
   output logic dest_valid,
   output logic dest_fifo,
   output fbp_pkg::dest_code_t dest_buffer,
   output fbp_pkg::filter_index_t dest_filter
);
   import fbp_pkg::*;

   // =======================================================================
   // helpers

   // pick the 4-bit pointer of a covered filter out of the two registers
   function automatic dest_code_t pointer_field(input filter_index_t idx, input ptr_reg_t p47,
                                                input ptr_reg_t p811);
      filter_index_t rel;
      rel = idx - `FIRST_FILTER;
      if (idx < 4'h8) begin
         pointer_field = p47[rel[1:0]*`FIELD_W +: `FIELD_W];
      end else begin
         pointer_field = p811[rel[1:0]*`FIELD_W +: `FIELD_W];
      end
   endfunction

   function automatic logic is_covered(input filter_index_t idx);
      is_covered = (idx >= `FIRST_FILTER) && (idx <= `LAST_FILTER);
   endfunction

   // =======================================================================
   // register file and bus

   ptr_reg_t filter_4_7_buffer_pointer;
   ptr_reg_t filter_8_11_buffer_pointer;
   ptr_reg_t filter_enable_bits;
   logic wr_pend;
   logic [7:0] wr_addr;
   ptr_reg_t next_ptr_4_7;
   ptr_reg_t next_ptr_8_11;
   ptr_reg_t next_filter_en;
   logic next_wr_pend;
   logic [7:0] next_wr_addr;
   bus_word_t next_hrdata;
   logic addr_ok;
   logic route_seen;
   logic next_route_seen;
   bus_word_t status_word;

   assign addr_ok = hsel && htrans[1] && hready;

   always_comb begin
      status_word = 32'h0000_0000;
      status_word[`STAT_BUF_LSB +: `FIELD_W] = dest_buffer;
      status_word[`STAT_FIFO_BIT] = dest_fifo;
      status_word[`STAT_SEEN_BIT] = route_seen;
      status_word[`STAT_FILTER_LSB +: `FIELD_W] = dest_filter;
   end

   always_comb begin
      next_ptr_4_7 = filter_4_7_buffer_pointer;
      next_ptr_8_11 = filter_8_11_buffer_pointer;
      next_filter_en = filter_enable_bits;
      next_wr_pend = addr_ok && hwrite;
      next_wr_addr = haddr;
      next_hrdata = hrdata;
      // data phase of a write; unmapped offsets are ignored
      if (wr_pend) begin
         if (wr_addr == `OFF_PTR_4_7) begin
            next_ptr_4_7 = hwdata[15:0];
         end else if (wr_addr == `OFF_PTR_8_11) begin
            next_ptr_8_11 = hwdata[15:0];
         end else if (wr_addr == `OFF_FILTER_EN) begin
            next_filter_en = hwdata[15:0];
         end
      end
      // read data is built from the next values so a read right after a write sees it
      if (addr_ok && !hwrite) begin
         if (haddr == `OFF_PTR_4_7) begin
            next_hrdata = {16'h0000, next_ptr_4_7};
         end else if (haddr == `OFF_PTR_8_11) begin
            next_hrdata = {16'h0000, next_ptr_8_11};
         end else if (haddr == `OFF_FILTER_EN) begin
            next_hrdata = {16'h0000, next_filter_en};
         end else if (haddr == `OFF_ROUTE_STATUS) begin
            next_hrdata = status_word;
         end else begin
            next_hrdata = 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         filter_4_7_buffer_pointer <= `RST_PTR;
         filter_8_11_buffer_pointer <= `RST_PTR;
         filter_enable_bits <= `RST_FILTER_EN;
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else if (ce) begin
         filter_4_7_buffer_pointer <= next_ptr_4_7;
         filter_8_11_buffer_pointer <= next_ptr_8_11;
         filter_enable_bits <= next_filter_en;
         wr_pend <= next_wr_pend;
         wr_addr <= next_wr_addr;
         hrdata <= next_hrdata;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // =======================================================================
   // hit routing

   dest_code_t hit_ptr;
   logic hit_fifo;
   dest_code_t hit_buffer;
   logic hit_enabled;
   logic hit_take;
   logic next_dest_valid;
   logic next_dest_fifo;
   dest_code_t next_dest_buffer;
   filter_index_t next_dest_filter;

   assign hit_ptr = pointer_field(hit_index, filter_4_7_buffer_pointer, filter_8_11_buffer_pointer);
   assign hit_enabled = filter_enable_bits[hit_index];
   // a disabled filter never accepts, so its pointer is never looked at
   assign hit_take = hit_valid && is_covered(hit_index) && hit_enabled;

   dest_decode u_decode (
      .code(hit_ptr),
      .to_fifo(hit_fifo),
      .buffer_index(hit_buffer)
   );

   always_comb begin
      next_dest_valid = hit_take;
      next_dest_fifo = dest_fifo;
      next_dest_buffer = dest_buffer;
      next_dest_filter = dest_filter;
      next_route_seen = route_seen;
      if (hit_take) begin
         next_dest_fifo = hit_fifo;
         next_dest_buffer = hit_buffer;
         next_dest_filter = hit_index;
         next_route_seen = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         dest_valid <= 1'b0;
         dest_fifo <= 1'b0;
         dest_buffer <= 4'h0;
         dest_filter <= 4'h0;
         route_seen <= 1'b0;
      end else if (ce) begin
         dest_valid <= next_dest_valid;
         dest_fifo <= next_dest_fifo;
         dest_buffer <= next_dest_buffer;
         dest_filter <= next_dest_filter;
         route_seen <= next_route_seen;
      end
   end

   // =======================================================================
   // assertions

   sequence s_take_hit;
      ce && hit_valid && is_covered(hit_index) && filter_enable_bits[hit_index];
   endsequence

   sequence s_route_buffer(dest_code_t code);
      dest_valid && !dest_fifo && (dest_buffer == code);
   endsequence

   property p_buffer_index;
      @(posedge mclk) disable iff (sys_rst)
      (s_take_hit and (hit_ptr <= `DEST_LAST_BUFFER)) |=> s_route_buffer($past(hit_ptr));
   endproperty
   a_buffer_index: assert property (p_buffer_index) else $error("hit did not reach its buffer");

   property p_zero_code;
      @(posedge mclk) disable iff (sys_rst)
      (s_take_hit and (hit_ptr == 4'h0)) |=> s_route_buffer(4'h0);
   endproperty
   a_zero_code: assert property (p_zero_code) else $error("code zero not routed to buffer zero");

   property p_filter7_field;
      @(posedge mclk) disable iff (sys_rst)
      (s_take_hit and (hit_index == 4'h7) and (filter_4_7_buffer_pointer[15:12] == 4'h3))
         |=> s_route_buffer(4'h3);
   endproperty
   a_filter7_field: assert property (p_filter7_field) else $error("filter 7 not in top nibble");

   property p_filter4_field;
      @(posedge mclk) disable iff (sys_rst)
      (s_take_hit and (hit_index == 4'h4))
         |=> (dest_fifo == ($past(filter_4_7_buffer_pointer[3:0]) == `DEST_FIFO_CODE));
   endproperty
   a_filter4_field: assert property (p_filter4_field) else $error("filter 4 not in low nibble");

   property p_filter9_field;
      @(posedge mclk) disable iff (sys_rst)
      (s_take_hit and (hit_index == 4'h9) and (filter_8_11_buffer_pointer[7:4] != `DEST_FIFO_CODE))
         |=> (dest_buffer == $past(filter_8_11_buffer_pointer[7:4])) && (dest_filter == 4'h9);
   endproperty
   a_filter9_field: assert property (p_filter9_field) else $error("filter 9 not in bits 7:4");

   property p_same_encoding;
      @(posedge mclk) disable iff (sys_rst)
      s_take_hit |=> dest_valid && (dest_fifo == ($past(hit_ptr) == `DEST_FIFO_CODE));
   endproperty
   a_same_encoding: assert property (p_same_encoding) else $error("field decoded differently");

   property p_write_stores;
      @(posedge mclk) disable iff (sys_rst)
      (ce && wr_pend && (wr_addr == `OFF_PTR_8_11)) |=> (filter_8_11_buffer_pointer == $past(hwdata[15:0]));
   endproperty
   a_write_stores: assert property (p_write_stores) else $error("pointer write lost");

   property p_reset_clear;
      @(posedge mclk)
      sys_rst |=> (filter_4_7_buffer_pointer == `RST_PTR) && (filter_8_11_buffer_pointer == `RST_PTR);
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("pointers not cleared by reset");

   property p_disabled_ignored;
      @(posedge mclk) disable iff (sys_rst)
      (ce && hit_valid && !filter_enable_bits[hit_index]) |=> !dest_valid;
   endproperty
   a_disabled_ignored: assert property (p_disabled_ignored) else $error("disabled filter accepted");

   property p_fifo_code;
      @(posedge mclk) disable iff (sys_rst)
      (s_take_hit and (hit_ptr == `DEST_FIFO_CODE)) |=> dest_valid && dest_fifo && (dest_buffer == 4'h0);
   endproperty
   a_fifo_code: assert property (p_fifo_code) else $error("all-ones code not sent to FIFO");
endmodule

/* File: test/tb_can_filter_buffer_pointer.sv */
// self-checking bench for the filter buffer pointer block
`timescale 1ns/1ps
`include "fbp_consts.svh"
module tb_can_filter_buffer_pointer;
   import fbp_pkg::*;
   // ==========================================================================
   // stimulus and model state
   logic mclk = 0, sys_rst = 1, ce = 1, hsel = 0, hwrite = 0, hready, hit_valid = 0, rd_pend = 0;
   logic [7:0] haddr = 0;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 3'h2;
   bus_word_t hwdata = 0, hrdata;
   logic hreadyout, hresp, dest_valid, dest_fifo;
   dest_code_t dest_buffer;
   filter_index_t hit_index = 0, dest_filter, lfil = 0;
   ptr_reg_t ptr47 = 0, ptr811 = 0, en = 16'hFFFF;
   logic seen = 0, lfifo = 0;
   logic [3:0] lbuf = 0;
   bus_word_t rq[$];
   logic [8:0] dq[$];
   int num_errors = 0, n_compared = 0, cyc = 0, seed = 32'hd789f4cd, r;
   // single slave, so its ready is the bus ready
   assign hready = hreadyout;
   can_filter_buffer_pointer dut (.mclk(mclk), .sys_rst(sys_rst), .ce(ce), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .hit_valid(hit_valid), .hit_index(hit_index),
      .dest_valid(dest_valid), .dest_fifo(dest_fifo), .dest_buffer(dest_buffer), .dest_filter(dest_filter));
   always #5 mclk = ~mclk;
   // ==========================================================================
   // checking
   task automatic end_sim;
      if (num_errors == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk_rd(input bus_word_t e, input bus_word_t g);
      n_compared++;
      if (g !== e || $isunknown(e)) begin
         num_errors++;
         $display("FAIL t=%0t read exp %h got %h", $time, e, g);
      end
   endtask
   task automatic chk_dest(input logic [8:0] e, input logic [8:0] g);
      n_compared++;
      if (g !== e || $isunknown(e)) begin
         num_errors++;
         $display("FAIL t=%0t dest exp %h got %h", $time, e, g);
      end
   endtask
   always @(posedge mclk) begin
      if (rd_pend && hreadyout === 1'b1) chk_rd(rq.size() ? rq.pop_front() : 'x, hrdata);
      if (rd_pend && hreadyout === 1'b1) chk_rd(32'h0000_0000, {31'h0, hresp});
      // outputs are unknown before the first reset edge
      if (!sys_rst && dest_valid !== 1'b0)
         chk_dest(dq.size() ? dq.pop_front() : 'x, {dest_fifo, dest_buffer, dest_filter});
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         end_sim();
      end
   end
   // ==========================================================================
   // bus master and hit driver
   function automatic bus_word_t exp_rd(input logic [7:0] a);
      case (a)
         `OFF_PTR_4_7: exp_rd = {16'h0000, ptr47};
         `OFF_PTR_8_11: exp_rd = {16'h0000, ptr811};
         `OFF_FILTER_EN: exp_rd = {16'h0000, en};
         `OFF_ROUTE_STATUS: exp_rd = {20'h00000, lfil, 2'b00, seen, lfifo, lbuf};
         default: exp_rd = 32'h00000000;
      endcase
   endfunction
   task automatic bus(input logic w, input logic [7:0] a, input bus_word_t d);
      @(posedge mclk);
      // a hit left standing would be taken again on every edge of the transfer
      hit_valid <= 0;
      hsel <= 1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      if (!w) begin
         rq.push_back(exp_rd(a));
         rd_pend <= 1;
      end
      do @(posedge mclk); while (hreadyout !== 1'b1);
      rd_pend <= 0;
      // upper half is dropped by the slave
      if (w && a == `OFF_PTR_4_7) ptr47 = d[15:0];
      if (w && a == `OFF_PTR_8_11) ptr811 = d[15:0];
      if (w && a == `OFF_FILTER_EN) en = d[15:0];
   endtask
   // drives one hit on the next edge; hit_off or the next bus call lowers hit_valid
   task automatic hit(input filter_index_t f);
      logic [31:0] all;
      logic [3:0] c;
      all = {ptr811, ptr47};
      @(posedge mclk);
      hit_valid <= 1;
      hit_index <= f;
      if (f >= 4 && f <= 11 && en[f]) begin
         c = all[(int'(f) - 4) * 4 +: 4];
         lfifo = (c == `DEST_FIFO_CODE);
         lbuf = lfifo ? 4'h0 : c;
         lfil = f;
         seen = 1;
         dq.push_back({lfifo, lbuf, f});
      end
   endtask
   task automatic hit_off;
      @(posedge mclk);
      hit_valid <= 0;
   endtask
   // ==========================================================================
   // scenarios
   initial begin
      repeat (8) @(posedge mclk);
      sys_rst <= 0;
      for (int a = 0; a < 20; a += 4) bus(0, a[7:0], 0);
      bus(1, `OFF_PTR_4_7, 32'hFFFF7654);
      bus(1, `OFF_PTR_8_11, 32'h1234BA98);
      bus(0, `OFF_PTR_4_7, 0);
      bus(0, `OFF_PTR_8_11, 0);
      for (int c = 0; c < 16; c++) begin
         bus(1, `OFF_PTR_4_7, {16'h0000, 4'(c + 3), 4'(c + 2), 4'(c + 1), 4'(c)});
         bus(1, `OFF_PTR_8_11, {16'h0000, 4'(c + 7), 4'(c + 6), 4'(c + 5), 4'(c + 4)});
         for (int f = 4; f < 12; f++) hit(4'(f));
         hit_off();
         bus(0, `OFF_ROUTE_STATUS, 0);
      end
      bus(1, `OFF_FILTER_EN, 32'h0000F00F);
      for (int f = 0; f < 16; f++) hit(4'(f));
      hit_off();
      for (int i = 0; i < 200; i++) begin
         r = $random(seed);
         if (r[1:0] == 2'b00) bus(1, {4'h0, r[3:2], 2'b00}, $random(seed));
         else if (r[1:0] == 2'b01) bus(0, {3'h0, r[4:2], 2'b00}, 0);
         else begin
            hit(r[7:4]);
            if (r[8]) hit_off();
         end
      end
      hit_off();
      repeat (4) @(posedge mclk);
      if (dq.size() != 0 || rq.size() != 0) num_errors++;
      end_sim();
   end
endmodule
